// file: core/acsrs_pkg.sv
// Package for the accumulator saturate, round and shift block
package acsrs_pkg;

	// Register byte offsets on the AHB-Lite bus
	localparam logic [7:0] OFS_CORE_CFG  = 8'h00;
	localparam logic [7:0] OFS_TRAP_CTRL = 8'h04;
	localparam logic [7:0] OFS_STATUS    = 8'h08;
	localparam logic [7:0] OFS_OPND_LO   = 8'h0C;
	localparam logic [7:0] OFS_OPND_HI   = 8'h10;
	localparam logic [7:0] OFS_XDATA     = 8'h14;
	localparam logic [7:0] OFS_COMMAND   = 8'h18;
	localparam logic [7:0] OFS_ACC_A_LO  = 8'h1C;
	localparam logic [7:0] OFS_ACC_A_HI  = 8'h20;
	localparam logic [7:0] OFS_ACC_B_LO  = 8'h24;
	localparam logic [7:0] OFS_ACC_B_HI  = 8'h28;
	localparam logic [7:0] OFS_WB_PTR    = 8'h2C;
	localparam logic [7:0] OFS_STORE_OUT = 8'h30;
	localparam logic [7:0] OFS_SHIFT_OUT = 8'h34;

	// Field positions in core_config_reg
	localparam int CFG_STORE_CLIP_BIT = 0;
	localparam int CFG_ROUND_SEL_BIT  = 1;
	localparam int CFG_WIDTH_SEL_BIT  = 4;
	localparam int CFG_CLIP_B_BIT     = 6;
	localparam int CFG_CLIP_A_BIT     = 7;
	// Field positions in trap_control_reg
	localparam int TRP_OVF_A_BIT   = 0;
	localparam int TRP_OVF_B_BIT   = 1;
	localparam int TRP_FATAL_BIT   = 2;
	// Field positions in the status register
	localparam int ST_GUARD_A_BIT  = 0;
	localparam int ST_GUARD_B_BIT  = 1;
	localparam int ST_GUARD_AB_BIT = 2;
	localparam int ST_CLIP_A_BIT   = 3;
	localparam int ST_CLIP_B_BIT   = 4;
	localparam int ST_CLIP_AB_BIT  = 5;

	// Reset values
	localparam logic [7:0]  CORE_CFG_RST  = 8'h00;
	localparam logic [2:0]  TRAP_CTRL_RST = 3'h0;
	localparam logic [15:0] WB_PTR_RST    = 16'h0000;

	// Saturation limits and data constants
	localparam logic [39:0] MAX_POS_931 = 40'h7FFFFFFFFF;
	localparam logic [39:0] MAX_NEG_931 = 40'h8000000000;
	localparam logic [39:0] MAX_POS_131 = 40'h007FFFFFFF;
	localparam logic [39:0] MAX_NEG_131 = 40'h0080000000;
	localparam logic [23:0] STORE_POS_LIM = 24'h007FFF;
	localparam logic [23:0] STORE_NEG_LIM = 24'hFF8000;
	localparam logic [15:0] STORE_POS_MAX = 16'h7FFF;
	localparam logic [15:0] STORE_NEG_MAX = 16'h8000;
	localparam logic [15:0] HALF_LSW      = 16'h8000;
	localparam logic [15:0] WB_STEP       = 16'h0002;

	// Operation codes
	typedef enum logic [2:0] {
		OP_ADD       = 3'b000,
		OP_MAC_WB    = 3'b001,
		OP_MAC_NOWB  = 3'b010,
		OP_STORE     = 3'b011,
		OP_SHIFT_DSP = 3'b100,
		OP_SHIFT_MCU = 3'b101
	} acsrs_op_type;

	// Command word layout
	typedef struct packed {
		logic [10:0]  rsvd_hi;
		logic [4:0]   shamt;
		logic [3:0]   rsvd_lo;
		logic         wb_ind;
		logic         wb_en;
		logic         rnd;
		logic         logical;
		logic         src_x;
		logic         cin;
		logic         zero;
		logic         sub;
		logic         tgt;
		acsrs_op_type op;
	} acsrs_cmd_type;

	// X bus write carrier
	typedef struct packed {
		logic        en;
		logic [15:0] addr;
		logic [15:0] data;
	} acsrs_xbus_type;

endpackage

// file: core/acsrs_core.sv
// Accumulator adder, saturation, rounding, write-back and barrel shifter
`timescale 1ns/1ps
module acsrs_core
(
	input  wire logic                     i_clk,
	input  wire logic                     i_rstn,
	input  wire logic                     i_hsel,
	input  wire logic [31:0]              i_haddr,
	input  wire logic [1:0]               i_htrans,
	input  wire logic                     i_hwrite,
	input  wire logic [2:0]               i_hsize,
	input  wire logic [31:0]              i_hwdata,
	input  wire logic                     i_hready,
	output logic                          o_hreadyout,
	output logic [31:0]                   o_hrdata,
	output logic                          o_hresp,
	output acsrs_pkg::acsrs_xbus_type     o_xbus,
	output logic                          o_arith_trap
);
	import acsrs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Datapath functions

	// Rounded high part, bits 39..16 plus the round increment
	function automatic logic [23:0] round_hi(input logic [39:0] acc,
		input logic rnd_req, input logic conv);
		logic inc;
		inc = rnd_req & acc[15];
		if (conv && acc[15:0] == HALF_LSW)
			inc = rnd_req & acc[16];
		round_hi = acc[39:16] + {23'h000000, inc};
	endfunction

	// Data space write saturation, sign taken from accumulator bit 39
	function automatic logic [15:0] store_word(input logic [23:0] r24,
		input logic sign, input logic clip_en);
		store_word = r24[15:0];
		if (clip_en && !sign && r24 > STORE_POS_LIM)
			store_word = STORE_POS_MAX;
		else if (clip_en && sign && r24 < STORE_NEG_LIM)
			store_word = STORE_NEG_MAX;
	endfunction

	// 40-bit barrel shifter; X data placed by direction
	function automatic logic [39:0] shift40(input logic [39:0] acc,
		input logic [15:0] xd, input logic src_x, input logic logical,
		input logic [4:0] amt);
		logic [39:0] opnd;
		logic [4:0]  mag;
		opnd = acc;
		mag  = amt[4] ? 5'(-amt) : amt;
		if (mag > 5'd16)
			mag = 5'd16;
		if (src_x && !amt[4])
			opnd = {(logical ? 8'h00 : {8{xd[15]}}), xd, 16'h0000};
		else if (src_x)
			opnd = {24'h000000, xd};
		if (amt[4])
			shift40 = opnd << mag;
		else if (logical)
			shift40 = opnd >> mag;
		else
			shift40 = 40'($signed(opnd) >>> mag);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	logic [7:0]  core_config_reg_r;
	logic [2:0]  trap_control_reg_r;
	logic [39:0] opnd_r;
	logic [15:0] xdata_r;
	logic [39:0] accum_a_r;
	logic [39:0] accum_b_r;
	logic [15:0] writeback_pointer_reg_r;
	logic [15:0] store_out_r;
	logic [15:0] shift_out_r;
	logic        acc_a_guard_ovf_r;
	logic        acc_b_guard_ovf_r;
	logic        acc_a_clip_flag_r;
	logic        acc_b_clip_flag_r;
	logic        either_guard_ovf_r;
	logic        either_clip_flag_r;
	logic        wr_pend_r;
	logic        rd_pend_r;
	logic [7:0]  addr_r;

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: writes zero-wait, reads one wait state

	logic addr_ok;
	logic wr_commit;
	assign addr_ok   = i_hsel & i_htrans[1] & i_hready;
	assign wr_commit = wr_pend_r;

	// Phase tracking; a read waits one cycle so it sees prior writes
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wr_pend_r   <= 1'b0;
			rd_pend_r   <= 1'b0;
			addr_r      <= 8'h00;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end
		else
		begin
			wr_pend_r   <= addr_ok & i_hwrite;
			rd_pend_r   <= addr_ok & ~i_hwrite;
			o_hreadyout <= ~(addr_ok & ~i_hwrite);
			o_hresp     <= 1'b0;
			if (addr_ok)
				addr_r <= {i_haddr[7:2], 2'b00};
		end
	end

	// Read mux; unmapped addresses read zero
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h00000000;
		case (addr_r)
			OFS_CORE_CFG:  rd_mux = {24'h000000, core_config_reg_r};
			OFS_TRAP_CTRL: rd_mux = {29'h00000000, trap_control_reg_r};
			OFS_STATUS:    rd_mux = {26'h0000000, either_clip_flag_r,
				acc_b_clip_flag_r, acc_a_clip_flag_r, either_guard_ovf_r,
				acc_b_guard_ovf_r, acc_a_guard_ovf_r};
			OFS_OPND_LO:   rd_mux = opnd_r[31:0];
			OFS_OPND_HI:   rd_mux = {24'h000000, opnd_r[39:32]};
			OFS_XDATA:     rd_mux = {16'h0000, xdata_r};
			OFS_ACC_A_LO:  rd_mux = accum_a_r[31:0];
			OFS_ACC_A_HI:  rd_mux = {24'h000000, accum_a_r[39:32]};
			OFS_ACC_B_LO:  rd_mux = accum_b_r[31:0];
			OFS_ACC_B_HI:  rd_mux = {24'h000000, accum_b_r[39:32]};
			OFS_WB_PTR:    rd_mux = {16'h0000, writeback_pointer_reg_r};
			OFS_STORE_OUT: rd_mux = {16'h0000, store_out_r};
			OFS_SHIFT_OUT: rd_mux = {16'h0000, shift_out_r};
			default:       rd_mux = 32'h00000000;
		endcase
	end

	// Read data registered in the wait cycle
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_hrdata <= 32'h00000000;
		else if (rd_pend_r)
			o_hrdata <= rd_mux;
	end

	// Plain configuration registers
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			core_config_reg_r  <= CORE_CFG_RST;
			trap_control_reg_r <= TRAP_CTRL_RST;
			opnd_r             <= 40'h0000000000;
			xdata_r            <= 16'h0000;
		end
		else if (wr_commit)
		begin
			case (addr_r)
				OFS_CORE_CFG:  core_config_reg_r  <= i_hwdata[7:0];
				OFS_TRAP_CTRL: trap_control_reg_r <= i_hwdata[2:0];
				OFS_OPND_LO:   opnd_r[31:0]       <= i_hwdata;
				OFS_OPND_HI:   opnd_r[39:32]      <= i_hwdata[7:0];
				OFS_XDATA:     xdata_r            <= i_hwdata[15:0];
				default:       ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command decode and adder

	acsrs_cmd_type cmd;
	logic          go;
	logic          adder_pass;
	assign cmd        = acsrs_cmd_type'(i_hwdata);
	assign go         = wr_commit && addr_r == OFS_COMMAND;
	assign adder_pass = go && (cmd.op == OP_ADD || cmd.op == OP_MAC_WB ||
		cmd.op == OP_MAC_NOWB);

	logic        clip_a_en;
	logic        clip_b_en;
	logic        width40;
	logic        conv_sel;
	logic        store_clip_enable;
	assign clip_a_en         = core_config_reg_r[CFG_CLIP_A_BIT];
	assign clip_b_en         = core_config_reg_r[CFG_CLIP_B_BIT];
	assign width40           = core_config_reg_r[CFG_WIDTH_SEL_BIT];
	assign conv_sel          = core_config_reg_r[CFG_ROUND_SEL_BIT];
	assign store_clip_enable = core_config_reg_r[CFG_STORE_CLIP_BIT];

	logic [39:0] tgt_acc;
	logic [39:0] oth_acc;
	logic [39:0] add_a;
	logic [39:0] add_b;
	logic [40:0] sum41;
	logic [39:0] sum;
	logic        true_neg;
	logic        ovf39;
	logic        ovf31;
	logic        guard_hit;
	logic        clip_en;
	assign tgt_acc  = cmd.tgt ? accum_b_r : accum_a_r;
	assign oth_acc  = cmd.tgt ? accum_a_r : accum_b_r;
	assign add_a    = cmd.zero ? 40'h0000000000 : tgt_acc;
	assign add_b    = cmd.sub ? ~opnd_r : opnd_r;
	// Carry is active high for add; for sub the same bit is borrow_n
	assign sum41    = {add_a[39], add_a} + {add_b[39], add_b}
		+ {40'h0000000000, cmd.cin};
	assign sum      = sum41[39:0];
	assign true_neg = sum41[40];
	assign ovf39    = sum41[40] ^ sum41[39];
	assign guard_hit = ~((&sum[39:32]) | ~(|sum[39:32]));
	assign ovf31    = ovf39 | ~((&sum[39:31]) | ~(|sum[39:31]));
	assign clip_en  = cmd.tgt ? clip_b_en : clip_a_en;

	// Saturation choice from result, overflow and mode bits
	logic [39:0] acc_res;
	logic        clip_set;
	logic        guard_new;
	logic        fatal_trap;
	always_comb
	begin
		acc_res    = sum;
		clip_set   = 1'b0;
		guard_new  = guard_hit;
		fatal_trap = 1'b0;
		if (clip_en && width40)
		begin
			clip_set = ovf39;
			if (ovf39)
				acc_res = true_neg ? MAX_NEG_931 : MAX_POS_931;
		end
		else if (clip_en)
		begin
			guard_new = 1'b0;
			clip_set  = ovf31;
			if (ovf31)
				acc_res = true_neg ? MAX_NEG_131 : MAX_POS_131;
		end
		else
		begin
			clip_set   = ovf39;
			fatal_trap = ovf39 &
				trap_control_reg_r[TRP_FATAL_BIT];
		end
	end

	// Shifter and store word
	logic [39:0] shifted;
	logic [15:0] st_word;
	logic [15:0] wb_word;
	assign shifted = shift40(tgt_acc, xdata_r, cmd.src_x, cmd.logical,
		cmd.shamt);
	assign st_word = store_word(round_hi(tgt_acc, cmd.rnd, conv_sel),
		tgt_acc[39], store_clip_enable);
	assign wb_word = store_word(round_hi(oth_acc, 1'b1, conv_sel),
		oth_acc[39], store_clip_enable);

	////////////////////////////////////////////////////////////////////////
	// Accumulators and flags

	logic clr_a;
	logic clr_b;
	assign clr_a = wr_commit && addr_r == OFS_STATUS &&
		i_hwdata[ST_CLIP_A_BIT];
	assign clr_b = wr_commit && addr_r == OFS_STATUS &&
		i_hwdata[ST_CLIP_B_BIT];

	// Accumulator update from adder or DSP shift
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			accum_a_r <= 40'h0000000000;
			accum_b_r <= 40'h0000000000;
		end
		else if (adder_pass && !cmd.tgt)
			accum_a_r <= acc_res;
		else if (adder_pass)
			accum_b_r <= acc_res;
		else if (go && cmd.op == OP_SHIFT_DSP && !cmd.tgt)
			accum_a_r <= shifted;
		else if (go && cmd.op == OP_SHIFT_DSP)
			accum_b_r <= shifted;
	end

	// Guard flags follow the latest pass; clip flags are sticky
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			acc_a_guard_ovf_r  <= 1'b0;
			acc_b_guard_ovf_r  <= 1'b0;
			acc_a_clip_flag_r  <= 1'b0;
			acc_b_clip_flag_r  <= 1'b0;
			either_guard_ovf_r <= 1'b0;
			either_clip_flag_r <= 1'b0;
			o_arith_trap       <= 1'b0;
		end
		else
		begin
			if (adder_pass && !cmd.tgt)
				acc_a_guard_ovf_r <= guard_new;
			if (adder_pass && cmd.tgt)
				acc_b_guard_ovf_r <= guard_new;
			// Software clear wins so a clear is never silently undone
			if (clr_a)
				acc_a_clip_flag_r <= 1'b0;
			else if (adder_pass && !cmd.tgt && clip_set)
				acc_a_clip_flag_r <= 1'b1;
			if (clr_b)
				acc_b_clip_flag_r <= 1'b0;
			else if (adder_pass && cmd.tgt && clip_set)
				acc_b_clip_flag_r <= 1'b1;
			either_guard_ovf_r <=
				(adder_pass && !cmd.tgt ? guard_new : acc_a_guard_ovf_r) |
				(adder_pass && cmd.tgt ? guard_new : acc_b_guard_ovf_r);
			either_clip_flag_r <=
				(~clr_a & (acc_a_clip_flag_r |
				(adder_pass & ~cmd.tgt & clip_set))) |
				(~clr_b & (acc_b_clip_flag_r |
				(adder_pass & cmd.tgt & clip_set)));
			o_arith_trap <= adder_pass & ((guard_new &
				trap_control_reg_r[cmd.tgt ? TRP_OVF_B_BIT
				: TRP_OVF_A_BIT]) | fatal_trap);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Store, write-back and X bus

	logic mac_wb;
	assign mac_wb = go && cmd.op == OP_MAC_WB && cmd.wb_en;

	// Write-back pointer: direct load or post-increment by a word
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			writeback_pointer_reg_r <= WB_PTR_RST;
		else if (mac_wb && !cmd.wb_ind)
			writeback_pointer_reg_r <= wb_word;
		else if (mac_wb)
			writeback_pointer_reg_r <= writeback_pointer_reg_r
				+ WB_STEP;
		else if (wr_commit && addr_r == OFS_WB_PTR)
			writeback_pointer_reg_r <= i_hwdata[15:0];
	end

	// One-cycle X bus write; store address taken from operand low word
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_xbus      <= '0;
			store_out_r <= 16'h0000;
			shift_out_r <= 16'h0000;
		end
		else
		begin
			o_xbus.en <= 1'b0;
			if (go && cmd.op == OP_STORE)
			begin
				o_xbus.en   <= 1'b1;
				o_xbus.addr <= opnd_r[15:0];
				o_xbus.data <= st_word;
				store_out_r <= st_word;
			end
			else if (mac_wb && cmd.wb_ind)
			begin
				o_xbus.en   <= 1'b1;
				o_xbus.addr <= writeback_pointer_reg_r;
				o_xbus.data <= wb_word;
			end
			if (go && cmd.op == OP_SHIFT_MCU)
				shift_out_r <= cmd.shamt[4] ? shifted[15:0]
					: shifted[31:16];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence pass_a_s;
		adder_pass && !cmd.tgt;
	endsequence

	sequence store_go_s;
		go && cmd.op == OP_STORE;
	endsequence

	sat40_limit_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		pass_a_s ##0 (clip_a_en && width40 && ovf39) |=>
		accum_a_r == ($past(true_neg) ? MAX_NEG_931 : MAX_POS_931)
		&& acc_a_clip_flag_r)
		else $error("40-bit clip value wrong");

	sat32_limit_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		pass_a_s ##0 (clip_a_en && !width40 && ovf31) |=>
		accum_a_r == ($past(true_neg) ? MAX_NEG_131 : MAX_POS_131))
		else $error("32-bit clip value wrong");

	guard_32mode_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		pass_a_s ##0 (clip_a_en && !width40) |=> !acc_a_guard_ovf_r)
		else $error("guard flag set in 32-bit mode");

	wrap_fatal_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		pass_a_s ##0 (!clip_a_en && ovf39 && !clr_a) |=>
		accum_a_r == $past(sum) && acc_a_clip_flag_r)
		else $error("catastrophic overflow not wrapped");

	clip_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		acc_a_clip_flag_r && !clr_a |=> acc_a_clip_flag_r)
		else $error("clip flag dropped by hardware");

	either_or_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		either_clip_flag_r == (acc_a_clip_flag_r | acc_b_clip_flag_r) &&
		either_guard_ovf_r == (acc_a_guard_ovf_r | acc_b_guard_ovf_r))
		else $error("combined status mismatch");

	guard_trap_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		pass_a_s ##0 (guard_new && trap_control_reg_r[TRP_OVF_A_BIT]) |=>
		o_arith_trap ##1 !o_arith_trap || $past(adder_pass))
		else $error("guard trap missing");

	wb_step_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		mac_wb && cmd.wb_ind |=> o_xbus.en &&
		writeback_pointer_reg_r == $past(writeback_pointer_reg_r) + WB_STEP)
		else $error("write-back pointer step wrong");

	store_pass_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		store_go_s ##0 (!store_clip_enable && !cmd.rnd) |=>
		o_xbus.en && o_xbus.data == $past(tgt_acc[31:16]))
		else $error("truncated store altered");

	store_clip_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		store_go_s ##0 (store_clip_enable && !tgt_acc[39] &&
		tgt_acc[39:31] != 9'h000) |=> o_xbus.data == STORE_POS_MAX)
		else $error("positive store clip missing");

endmodule

// file: dv/acsrs_xmem.sv
// Data-space sink model that takes the block's X bus word writes
`timescale 1ns/1ps
module acsrs_xmem
(
	input  wire logic                      i_clk,
	input  wire logic                      i_rstn,
	input  wire acsrs_pkg::acsrs_xbus_type i_xbus,
	input  wire logic [15:0]               i_peek_addr,
	output logic [7:0]                     o_count,
	output logic [15:0]                    o_peek
);
	import acsrs_pkg::*;
	logic [15:0] mem_r [0:255];

	// Read port so the bench can see what really landed in data space
	assign o_peek = mem_r[i_peek_addr[8:1]];

	////////////////////////////////////////////////////////////////////////
	// Word store; the count lets the bench spot writes that should not be
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_count <= 8'h00;
		else if (i_xbus.en)
		begin
			mem_r[i_xbus.addr[8:1]] <= i_xbus.data; // Word address, bit 0 unused
			o_count <= o_count + 8'h01;
		end
	end
endmodule

// file: dv/accumulator_saturate_round_shift_tb.sv
// Self-checking bench for the accumulator saturate, round and shift block
`timescale 1ns/1ps
module accumulator_saturate_round_shift_tb;
	import acsrs_pkg::*;
	localparam logic [8:0] F_TGT = 9'h001, F_SUB = 9'h002, F_ZERO = 9'h004;
	localparam logic [8:0] F_CIN = 9'h008, F_SRCX = 9'h010, F_LOG = 9'h020;
	localparam logic [8:0] F_RND = 9'h040, F_WB = 9'h080, F_IND = 9'h100;
	localparam logic [39:0] SV [6] = '{40'h0012348000, 40'h0012358000,
		40'h007FFF8000, 40'h00FFFF7FFF, 40'h0100000000, 40'hFF00000000};
	logic           i_clk, i_rstn, i_hsel, i_hwrite, o_hreadyout;
	logic           o_hresp, o_arith_trap, rd_ph;
	logic [31:0]    i_haddr, i_hwdata, o_hrdata;
	logic [1:0]     i_htrans;
	logic [2:0]     i_hsize;
	logic [7:0]     x_count;
	logic [15:0]    st_addr;
	logic [39:0]    ra;
	logic [15:0]    peek;
	acsrs_xbus_type o_xbus;
	acsrs_xbus_type xq [$];
	logic [31:0]    rq [$];
	int             failures, n_compared, traps, seed, k;

	acsrs_core DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(i_hsel),
		.i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
		.i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
		.o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp),
		.o_xbus(o_xbus), .o_arith_trap(o_arith_trap));
	acsrs_xmem XMEM (.i_clk(i_clk), .i_rstn(i_rstn), .i_xbus(o_xbus),
		.i_peek_addr(16'h0100), .o_count(x_count), .o_peek(peek));

	////////////////////////////////////////////////////////////////////////
	// Clock at 40 MHz
	initial i_clk = 1'b0;
	always #12.5 i_clk = ~i_clk;

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_xbus(input acsrs_xbus_type got, acsrs_xbus_type exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: xbus %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("Compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// One AHB single transfer; waits are bounded only by the watchdog
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge i_clk);
		i_hsel <= 1'b1;
		i_htrans <= 2'b10;
		i_haddr <= {24'h0, a};
		i_hwrite <= w;
		do @(posedge i_clk); while (o_hreadyout !== 1'b1);
		i_hsel <= 1'b0;
		i_htrans <= 2'b00;
		i_hwdata <= d;
		rd_ph <= !w;
		do @(posedge i_clk); while (o_hreadyout !== 1'b1);
		rd_ph <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask
	function automatic logic [31:0] mk(acsrs_op_type op, logic [8:0] f,
		logic [4:0] sh);
		return {11'h0, sh, 4'h0, f, op};
	endfunction
	// Load an accumulator through the adder with the accumulator side zeroed
	task automatic ld(input logic t, input logic [39:0] v);
		wr(OFS_OPND_LO, v[31:0]);
		wr(OFS_OPND_HI, {24'h0, v[39:32]});
		wr(OFS_COMMAND, mk(OP_ADD, F_ZERO | {8'h0, t}, 5'h00));
	endtask
	task automatic step(input logic [8:0] f);
		wr(OFS_OPND_LO, 32'h1);
		wr(OFS_OPND_HI, 32'h0);
		wr(OFS_COMMAND, mk(OP_ADD, f, 5'h00));
	endtask
	task automatic racc(input logic t, input logic [39:0] v);
		rd(t ? OFS_ACC_B_LO : OFS_ACC_A_LO, v[31:0]);
		rd(t ? OFS_ACC_B_HI : OFS_ACC_A_HI, {24'h0, v[39:32]});
	endtask
	// Expected stored word: round or truncate, then optional store clip
	function automatic logic [15:0] st_exp(logic [39:0] a, logic cv,
		logic rn, logic cl);
		logic [23:0] v;
		logic        inc;
		inc = (cv && a[15:0] == HALF_LSW) ? a[16] : a[15];
		v = a[39:16] + {23'h0, rn & inc};
		if (cl && !a[39] && v > STORE_POS_LIM) return STORE_POS_MAX;
		if (cl && a[39] && v < STORE_NEG_LIM) return STORE_NEG_MAX;
		return v[15:0];
	endfunction
	task automatic store(input logic [39:0] a, input logic [1:0] c,
		input logic rn);
		wr(OFS_CORE_CFG, {30'h0, c});
		ld(1'b0, a);
		wr(OFS_OPND_LO, {16'h0, st_addr});
		xq.push_back({1'b1, st_addr, st_exp(a, c[1], rn, c[0])});
		wr(OFS_COMMAND, mk(OP_STORE, rn ? F_RND : 9'h0, 5'h00));
		st_addr = st_addr + 16'h0002;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Result watcher: read data, X bus writes and trap pulses
	always @(posedge i_clk)
	begin
		if (rd_ph && o_hreadyout) cmp_word(o_hrdata, rq.pop_front());
		if (o_xbus.en === 1'b1) cmp_xbus(o_xbus, xq.pop_front());
		if (o_arith_trap === 1'b1) traps++;
	end

	// Watchdog far beyond the roughly 1340 cycles the sequence needs
	initial
	begin
		#(25 * 40000);
		failures++;
		tally_and_finish;
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{i_hsel, i_hwrite, rd_ph, i_haddr, i_hwdata, i_htrans} = '0;
		i_hsize = 3'b010;
		i_rstn = 1'b0;
		seed = 32'hB664;
		st_addr = 16'h0200;
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		rd(OFS_CORE_CFG, 32'h0);
		rd(OFS_TRAP_CTRL, 32'h0);
		rd(OFS_WB_PTR, 32'h0);
		rd(8'h3C, 32'h0);
		rd(OFS_STATUS, 32'h0);
		ld(1'b0, MAX_POS_931);
		rd(OFS_STATUS, 32'h05);
		wr(OFS_TRAP_CTRL, 32'h4);
		step(9'h0);
		racc(1'b0, MAX_NEG_931);
		rd(OFS_STATUS, 32'h2D);
		cmp_word(traps, 32'd1);
		wr(OFS_TRAP_CTRL, 32'h1);
		ld(1'b0, 40'h5);
		rd(OFS_STATUS, 32'h28);
		wr(OFS_STATUS, 32'h08);
		rd(OFS_STATUS, 32'h00);
		ld(1'b0, MAX_POS_931);
		ld(1'b1, MAX_POS_931);
		rd(OFS_STATUS, 32'h07);
		cmp_word(traps, 32'd2);
		wr(OFS_TRAP_CTRL, 32'h0);
		wr(OFS_CORE_CFG, 32'h90);
		step(9'h0);
		racc(1'b0, MAX_POS_931);
		ld(1'b0, MAX_NEG_931);
		step(F_SUB | F_CIN);
		racc(1'b0, MAX_NEG_931);
		rd(OFS_STATUS, 32'h2F);
		wr(OFS_STATUS, 32'h18);
		wr(OFS_CORE_CFG, 32'h80);
		ld(1'b1, 40'h0);
		ld(1'b0, 40'h007FFFFFFF);
		step(9'h0);
		racc(1'b0, MAX_POS_131);
		ld(1'b0, 40'hFF80000000);
		step(F_SUB | F_CIN);
		racc(1'b0, MAX_NEG_131);
		rd(OFS_STATUS, 32'h28);
		for (k = 0; k < 56; k++)
		begin
			ra = {8'($random(seed)), 32'($random(seed))};
			store((k < 48) ? SV[k / 8] : ra, k[2:1], k[0]);
		end
		ld(1'b1, 40'h0012348000);
		// Store loop leaves convergent rounding on; the tie below wants bias
		wr(OFS_CORE_CFG, 32'h0);
		wr(OFS_WB_PTR, 32'h0100);
		xq.push_back({1'b1, 16'h0100, 16'h1235});
		wr(OFS_COMMAND, mk(OP_MAC_WB, F_WB | F_IND, 5'h00));
		rd(OFS_WB_PTR, 32'h0102);
		wr(OFS_COMMAND, mk(OP_MAC_WB, F_WB, 5'h00));
		rd(OFS_WB_PTR, 32'h1235);
		wr(OFS_COMMAND, mk(OP_MAC_NOWB, F_WB | F_IND, 5'h00));
		rd(OFS_WB_PTR, 32'h1235);
		wr(OFS_XDATA, 32'h8421);
		wr(OFS_COMMAND, mk(OP_SHIFT_MCU, F_SRCX | F_LOG, 5'h04));
		rd(OFS_SHIFT_OUT, 32'h0842);
		wr(OFS_COMMAND, mk(OP_SHIFT_MCU, F_SRCX, 5'h1C));
		rd(OFS_SHIFT_OUT, 32'h4210);
		ld(1'b0, 40'hFF80000000);
		wr(OFS_COMMAND, mk(OP_SHIFT_DSP, 9'h0, 5'h04));
		racc(1'b0, 40'hFFF8000000);
		wr(OFS_COMMAND, mk(OP_SHIFT_DSP, 9'h0, 5'h00));
		racc(1'b0, 40'hFFF8000000);
		ld(1'b1, 40'h0000001234);
		wr(OFS_COMMAND, mk(OP_SHIFT_DSP, F_TGT, 5'h10));
		racc(1'b1, 40'h0012340000);
		cmp_word({24'h0, x_count}, 32'd57);
		cmp_word(traps, 32'd2);
		cmp_word(xq.size(), 32'd0);
		cmp_word({16'h0, peek}, 32'h1235);
		tally_and_finish;
	end
endmodule
